// File: rtl/bus_special_pkg.sv
package bus_special_pkg;

  localparam int          DATA_W            = 32;
  localparam int          ADDR_W            = 30;
  localparam int          CLK_PERIOD_PS     = 8000;
  // Cycle addresses are word addresses; lanes pick the byte
  localparam logic [29:0] INTA1_ADDR        = 30'h0000_0001;
  localparam logic [29:0] INTA2_ADDR        = 30'h0000_0000;
  localparam logic [29:0] HALT_ADDR         = 30'h0000_0000;
  localparam logic [29:0] SHUT_ADDR         = 30'h0000_0000;
  localparam logic [3:0]  INTA_BE_N         = 4'he;
  localparam logic [3:0]  HALT_BE_N         = 4'hb;
  localparam logic [3:0]  SHUT_BE_N         = 4'he;
  localparam logic [3:0]  IDLE_GAP_DOUBLED  = 4'h4;
  localparam logic [3:0]  IDLE_GAP_NORMAL   = 4'h8;
  localparam logic [1:0]  FLUSH_MIN_PERIODS = 2'h2;
  localparam int          CACHE_WAYS        = 2;
  localparam int          CACHE_SETS        = 1024;
  localparam int          SET_W             = 10;
  localparam int          TAG_W             = 20;
  localparam int          SYNC_W            = 40;
  localparam logic [39:0] SYNC_RST          = {8'hf9, 32'h0000_0000};
  localparam int          HSYNC_W           = 71;
  localparam logic [70:0] HSYNC_RST         = {2'h3, 3'h0, 4'hf, 30'h0, 32'h0};

  typedef enum logic [2:0] {
    CYC_MEM, CYC_INTA1, CYC_INTA2, CYC_HALT, CYC_SHUT
  } cyc_kind_t;

endpackage : bus_special_pkg

// File: rtl/cpu_bus_if.sv
`timescale 1ns/1ps
interface cpu_bus_if;
  logic [29:0] addr;
  logic [3:0]  byte_lane_enables_n;
  logic        addr_strobe_n;
  logic        mem_io;
  logic        data_ctrl;
  logic        write_rd;
  logic        bus_lock_n;
  logic [31:0] dev_data;
  logic        dev_data_oe_n;
  logic        cycle_done_n;
  logic        half_width_bus_req_n;
  logic        next_addr_req_n;
  logic        cache_enable_in_n;
  logic        flush_req_n;
  logic        maskable_int_req;
  logic        nmi_req;
  logic        mgmt_int_req_n;
  logic [31:0] sys_data;
  logic        sys_data_oe_n;
  wire  [31:0] data_bus;

  // Floating bus reads as pulled high
  assign data_bus = !dev_data_oe_n ? dev_data : (!sys_data_oe_n ? sys_data : 32'hffff_ffff);

  modport dev (
    output addr, byte_lane_enables_n, addr_strobe_n, mem_io, data_ctrl, write_rd, bus_lock_n,
    output dev_data, dev_data_oe_n,
    input  cycle_done_n, half_width_bus_req_n, next_addr_req_n, cache_enable_in_n, flush_req_n,
    input  maskable_int_req, nmi_req, mgmt_int_req_n, data_bus
  );

  modport sys (
    input  addr, byte_lane_enables_n, addr_strobe_n, mem_io, data_ctrl, write_rd, bus_lock_n,
    input  data_bus,
    output cycle_done_n, half_width_bus_req_n, next_addr_req_n, cache_enable_in_n, flush_req_n,
    output maskable_int_req, nmi_req, mgmt_int_req_n, sys_data, sys_data_oe_n
  );
endinterface : cpu_bus_if

// File: rtl/cpu_bus_sys.sv
`timescale 1ns/1ps
module cpu_bus_sys (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  cpu_bus_if.sys           bus,
  input  wire logic [3:0]  wait_states_in,
  input  wire logic        half_width_mode_in,
  input  wire logic        next_addr_mode_in,
  input  wire logic        cache_enable_mode_in,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        int_req_in,
  input  wire logic [7:0]  int_vector_in,
  input  wire logic        nmi_in,
  input  wire logic        mgmt_int_in,
  input  wire logic        flush_in,
  output logic             cyc_valid_out,
  output logic [29:0]      cyc_addr_out,
  output logic [3:0]       cyc_be_n_out,
  output logic [2:0]       cyc_def_out,
  output logic             cyc_locked_out,
  output logic [31:0]      cyc_wdata_out,
  output logic             int_ack_out
);
  import bus_special_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_READY} hstate_t;

  hstate_t              state_r;
  logic [HSYNC_W-1:0]   sync1_r, sync2_r;
  logic                 ads_prev_r;
  logic [4:0]           cnt_r;
  logic [1:0]           flush_cnt_r;
  logic                 ready_n_r, hw_n_r, na_n_r, ken_n_r, int_r, nmi_r, smi_n_r;
  logic [31:0]          rdata_r;

  wire [HSYNC_W-1:0] pins_raw = {bus.addr_strobe_n, bus.bus_lock_n, bus.mem_io, bus.data_ctrl,
                                 bus.write_rd, bus.byte_lane_enables_n, bus.addr, bus.data_bus};
  wire        s_ads_n  = sync2_r[70];
  wire        s_lock_n = sync2_r[69];
  wire [2:0]  s_def    = sync2_r[68:66];
  wire [3:0]  s_be_n   = sync2_r[65:62];
  wire [29:0] s_addr   = sync2_r[61:32];
  wire [31:0] s_data   = sync2_r[31:0];
  wire        start    = ads_prev_r && !s_ads_n;
  wire        is_inta2 = (s_def == 3'h0) && (s_addr == INTA2_ADDR);

  assign bus.cycle_done_n         = ready_n_r;
  assign bus.half_width_bus_req_n = hw_n_r;
  assign bus.next_addr_req_n      = na_n_r;
  assign bus.cache_enable_in_n    = ken_n_r;
  assign bus.flush_req_n          = (flush_cnt_r == 2'h0);
  assign bus.maskable_int_req     = int_r;
  assign bus.nmi_req              = nmi_r;
  assign bus.mgmt_int_req_n       = smi_n_r;
  assign bus.sys_data             = rdata_r;
  assign bus.sys_data_oe_n        = !(state_r == H_READY && !cyc_def_out[0]);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1_r <= HSYNC_RST;
      sync2_r <= HSYNC_RST;
    end else if (ce_in) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      int_r       <= 1'b0;
      nmi_r       <= 1'b0;
      smi_n_r     <= 1'b1;
      flush_cnt_r <= 2'h0;
    end else if (ce_in) begin
      int_r   <= int_req_in;
      nmi_r   <= nmi_in;
      smi_n_r <= !mgmt_int_in;
      if (flush_in)
        flush_cnt_r <= FLUSH_MIN_PERIODS;                                   // [RULE_22]
      else if (flush_cnt_r != 2'h0)
        flush_cnt_r <= flush_cnt_r - 2'h1;
    end
  end

  // Every cycle, halt and shutdown included, is answered with completion
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r        <= H_IDLE;
      ads_prev_r     <= 1'b1;
      cnt_r          <= 5'h0;
      ready_n_r      <= 1'b1;
      hw_n_r         <= 1'b1;
      na_n_r         <= 1'b1;
      ken_n_r        <= 1'b1;
      rdata_r        <= 32'h0;
      cyc_valid_out  <= 1'b0;
      cyc_addr_out   <= 30'h0;
      cyc_be_n_out   <= 4'hf;
      cyc_def_out    <= 3'h0;
      cyc_locked_out <= 1'b0;
      cyc_wdata_out  <= 32'h0;
      int_ack_out    <= 1'b0;
    end else if (ce_in) begin
      ads_prev_r    <= s_ads_n;
      cyc_valid_out <= 1'b0;
      int_ack_out   <= 1'b0;
      unique case (state_r)
        H_IDLE: if (start) begin
          cyc_addr_out   <= s_addr;
          cyc_be_n_out   <= s_be_n;
          cyc_def_out    <= s_def;
          cyc_locked_out <= !s_lock_n;
          cyc_wdata_out  <= s_data;
          rdata_r        <= is_inta2 ? {24'h0, int_vector_in} : rd_data_in;  // [RULE_13]
          hw_n_r         <= !half_width_mode_in;
          na_n_r         <= !next_addr_mode_in;
          ken_n_r        <= !cache_enable_mode_in;
          cnt_r          <= {wait_states_in, 1'b0};
          state_r        <= H_WAIT;
        end
        H_WAIT: if (cnt_r == 5'h0) begin
          ready_n_r <= 1'b0;                                                // [RULE_15] [RULE_17]
          cnt_r     <= 5'h1;
          state_r   <= H_READY;
        end else begin
          cnt_r <= cnt_r - 5'h1;
        end
        H_READY: if (cnt_r == 5'h0) begin
          ready_n_r     <= 1'b1;
          hw_n_r        <= 1'b1;
          na_n_r        <= 1'b1;
          ken_n_r       <= 1'b1;
          cyc_valid_out <= 1'b1;
          int_ack_out   <= (cyc_def_out == 3'h0) && (cyc_addr_out == INTA2_ADDR);
          state_r       <= H_IDLE;
        end else begin
          cnt_r <= cnt_r - 5'h1;
        end
      endcase
    end
  end

endmodule : cpu_bus_sys

// File: rtl/cpu_bus_dev.sv
`timescale 1ns/1ps
// Operation
// RULE_01 - Half-width cycles use only low sixteen lines
// RULE_02 - Upper-only half-width read taken from low lines
// RULE_03 - Upper-only half-width write duplicated, no extra cycle
// RULE_04 - Spanning half-width read: two low-line reads
// RULE_05 - Spanning write: bytes 0-1, then 2-3
// RULE_06 - Next-address and half-width never both honoured
// RULE_07 - Lock for locked RMW and interrupt acknowledge
// RULE_08 - Lock from first start to last completion
// RULE_09 - Lock valid in phase one of first state
// RULE_10 - Interrupt gives two locked acknowledge cycles
// RULE_11 - Acknowledge addresses 4h then 0h, lane zero
// RULE_12 - Four or eight idles, lock held throughout
// RULE_13 - Vector on D7-D0 of second cycle only
// RULE_14 - Halt cycle: address 2h, lane two, unlocked
// RULE_15 - Halt completed; resume on interrupts or reset
// RULE_16 - Shutdown cycle: address 0h, lane zero
// RULE_17 - Shutdown completed; resume on NMI or reset
// RULE_18 - 8K two-way cache, 1024 sets, read-allocate
// RULE_19 - Cache unlocked cacheable reads; pin gated by bit
// RULE_20 - Cache enable sampled one period before completion
// RULE_21 - Whole-cache invalidate on instruction, hold, flush
// RULE_22 - Flush sampled at phase two, two periods; code samples it at the end of phase one
// RULE_23 - Split access done after second part completes
module cpu_bus_dev (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  cpu_bus_if.dev           bus,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_write_in,
  input  wire logic        req_mem_in,
  input  wire logic [29:0] req_addr_in,
  input  wire logic [3:0]  req_be_n_in,
  input  wire logic [31:0] req_wdata_in,
  input  wire logic        req_lock_in,
  input  wire logic        req_lock_last_in,
  input  wire logic        req_noncache_in,
  output logic             done_out,
  output logic [31:0]      rdata_out,
  input  wire logic        int_enable_in,
  input  wire logic        clock_doubled_in,
  input  wire logic        halt_req_in,
  input  wire logic        shutdown_req_in,
  input  wire logic        invalidate_req_in,
  input  wire logic        hold_grant_in,
  input  wire logic        cache_enable_pin_bit_in,
  input  wire logic        invalidate_on_hold_bit_in,
  input  wire logic        flush_enable_bit_in,
  output logic             vector_valid_out,
  output logic [7:0]       vector_out,
  output logic             halted_out,
  output logic             shut_down_out,
  input  wire logic [29:0] lookup_addr_in,
  output logic [1:0]       lookup_hit_halves_out,
  output logic [31:0]      lookup_data_out
);
  import bus_special_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_GAP, ST_HALT, ST_SHUT} bstate_t;

  bstate_t           state_r;
  cyc_kind_t         kind_r;
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic              ph_r, lock_r, lockcyc_r, lock_last_r, noncache_r, second_r;
  logic              hw_r, na_r, ken_r, int_armed_r, halt_pend_r, shut_pend_r;
  logic              hold_prev_r, mio_r, dc_r, wr_r;
  logic [29:0]       addr_r;
  logic [3:0]        be_n_r, gap_r;
  logic [31:0]       wdata_r;
  logic [15:0]       rlow_r;
  logic [TAG_W-1:0]  tag_r   [CACHE_WAYS][CACHE_SETS];
  logic [31:0]       cdata_r [CACHE_WAYS][CACHE_SETS];
  logic [1:0]        valid_r [CACHE_WAYS][CACHE_SETS];
  logic              lru_r   [CACHE_SETS];

  function automatic logic way_hit(input logic w, input logic [SET_W-1:0] s,
                                   input logic [TAG_W-1:0] t);
    way_hit = (tag_r[w][s] == t) && (valid_r[w][s] != 2'h0);
  endfunction : way_hit

  wire [SYNC_W-1:0] pins_raw = {bus.cycle_done_n, bus.half_width_bus_req_n, bus.next_addr_req_n,
                                bus.cache_enable_in_n, bus.flush_req_n, bus.maskable_int_req,
                                bus.nmi_req, bus.mgmt_int_req_n, bus.data_bus};
  wire        s_ready  = !sync2_r[39];
  wire        s_hw     = !sync2_r[38];
  wire        s_na     = !sync2_r[37];
  wire        s_ken    = !sync2_r[36];
  wire        s_flush  = !sync2_r[35];
  wire        s_maskable_int_req   = sync2_r[34];
  wire        s_nmi    = sync2_r[33];
  wire        s_smi    = !sync2_r[32];
  wire [31:0] s_data   = sync2_r[31:0];
  wire [15:0] d_lo     = s_data[15:0];

  wire ph1_end    = ce_in && !ph_r;
  wire ph_end     = ce_in && ph_r;
  wire int_go     = int_armed_r && s_maskable_int_req && int_enable_in && !lock_r;          // [RULE_10]
  wire idle_go    = (state_r == ST_IDLE) && ph_end;
  wire req_go     = req_valid_in && !shut_pend_r && !halt_pend_r && !int_go;
  wire upper_only = &be_n_r[1:0];
  wire split_need = hw_r && !second_r && !upper_only && !(&be_n_r[3:2]);       // [RULE_04] [RULE_05]
  wire ready_hit  = (state_r == ST_T2) && ph_end && s_ready;
  wire cacheable  = !noncache_r && (!cache_enable_pin_bit_in || ken_r);         // [RULE_19]
  wire fill_ok    = ready_hit && kind_r == CYC_MEM && mio_r && !wr_r
                    && !lockcyc_r && cacheable;                                 // [RULE_18] [RULE_20]
  wire flush_hit  = ph1_end && s_flush && flush_enable_bit_in;                  // [RULE_22]
  wire hold_hit   = ce_in && hold_grant_in && !hold_prev_r && invalidate_on_hold_bit_in;
  wire inv_now    = (ce_in && invalidate_req_in) || hold_hit || flush_hit;     // [RULE_21]

  wire [SET_W-1:0] f_set    = addr_r[SET_W-1:0];
  wire [TAG_W-1:0] f_tag    = addr_r[29:SET_W];
  wire             f_hit0   = way_hit(1'b0, f_set, f_tag);
  wire             f_hit1   = way_hit(1'b1, f_set, f_tag);
  wire             f_way    = f_hit0 ? 1'b0 : (f_hit1 ? 1'b1 : lru_r[f_set]);
  wire [1:0]       f_halves = !hw_r ? 2'h3 : ((second_r || upper_only) ? 2'h2 : 2'h1);
  wire [31:0]      f_data   = hw_r ? {d_lo, d_lo} : s_data;
  wire [1:0]       f_keep   = (f_hit0 || f_hit1) ? valid_r[f_way][f_set] : 2'h0;
  wire [SET_W-1:0] l_set    = lookup_addr_in[SET_W-1:0];
  wire [TAG_W-1:0] l_tag    = lookup_addr_in[29:SET_W];
  wire             l_hit1   = way_hit(1'b1, l_set, l_tag);

  assign req_ready_out           = idle_go && req_go;
  assign halted_out              = (state_r == ST_HALT);
  assign shut_down_out           = (state_r == ST_SHUT);
  assign bus.addr                = addr_r;
  assign bus.byte_lane_enables_n = be_n_r;
  assign bus.addr_strobe_n       = !(state_r == ST_T1);
  assign bus.mem_io              = mio_r;
  assign bus.data_ctrl           = dc_r;
  assign bus.write_rd            = wr_r;
  assign bus.bus_lock_n          = !lock_r;                                     // [RULE_07]
  assign bus.dev_data            = wdata_r;
  assign bus.dev_data_oe_n       = !((state_r == ST_T1 || state_r == ST_T2) && kind_r == CYC_MEM
                                     && wr_r);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1_r      <= SYNC_RST;
      sync2_r      <= SYNC_RST;
      ph_r         <= 1'b0;
      hold_prev_r  <= 1'b0;
    end else if (ce_in) begin
      sync1_r      <= pins_raw;
      sync2_r      <= sync1_r;
      ph_r         <= !ph_r;
      hold_prev_r  <= hold_grant_in;
    end
  end

  // Bus cycle sequencer; states other than halt and shutdown advance at the end of phase two
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;   kind_r <= CYC_MEM;    addr_r <= 30'h0;   be_n_r <= 4'hf;
      wdata_r <= 32'h0;     rlow_r <= 16'h0;      mio_r <= 1'b0;     dc_r <= 1'b0;
      wr_r <= 1'b0;         lock_r <= 1'b0;       lockcyc_r <= 1'b0; lock_last_r <= 1'b0;
      noncache_r <= 1'b0;   second_r <= 1'b0;     hw_r <= 1'b0;      na_r <= 1'b0;
      ken_r <= 1'b0;        gap_r <= 4'h0;        int_armed_r <= 1'b1;
      halt_pend_r <= 1'b0;  shut_pend_r <= 1'b0;  done_out <= 1'b0;  rdata_out <= 32'h0;
      vector_valid_out <= 1'b0;                   vector_out <= 8'h0;
    end else if (ce_in) begin
      done_out         <= 1'b0;
      vector_valid_out <= 1'b0;
      if (!s_maskable_int_req) int_armed_r <= 1'b1;
      if (state_r == ST_T2 && ph1_end && !na_r) begin
        if (s_hw) hw_r <= 1'b1;                                                 // [RULE_06]
        else if (s_na) na_r <= 1'b1;
      end
      if (state_r == ST_T2 && ph1_end) ken_r <= s_ken;                          // [RULE_20]
      unique case (state_r)
        ST_IDLE: if (ph_end) begin
          hw_r <= 1'b0;  na_r <= 1'b0;  second_r <= 1'b0;  lockcyc_r <= 1'b0;
          if (shut_pend_r) begin
            shut_pend_r <= 1'b0;  kind_r <= CYC_SHUT;  addr_r <= SHUT_ADDR;     // [RULE_16]
            be_n_r <= SHUT_BE_N;  {mio_r, dc_r, wr_r} <= 3'b101;  state_r <= ST_T1;
          end else if (halt_pend_r) begin
            halt_pend_r <= 1'b0;  kind_r <= CYC_HALT;  addr_r <= HALT_ADDR;     // [RULE_14]
            be_n_r <= HALT_BE_N;  {mio_r, dc_r, wr_r} <= 3'b101;  state_r <= ST_T1;
          end else if (int_go) begin
            kind_r <= CYC_INTA1;  addr_r <= INTA1_ADDR;  be_n_r <= INTA_BE_N;   // [RULE_11]
            {mio_r, dc_r, wr_r} <= 3'b000;  lock_r <= 1'b1;  lockcyc_r <= 1'b1; // [RULE_08] [RULE_09]
            state_r <= ST_T1;
          end else if (req_go) begin
            kind_r <= CYC_MEM;  addr_r <= req_addr_in;  be_n_r <= req_be_n_in;
            {mio_r, dc_r, wr_r} <= {req_mem_in, 1'b1, req_write_in};
            wdata_r <= (&req_be_n_in[1:0]) ? {req_wdata_in[31:16], req_wdata_in[31:16]}
                                           : req_wdata_in;                      // [RULE_03]
            lockcyc_r <= req_lock_in;  lock_last_r <= req_lock_last_in;
            noncache_r <= req_noncache_in;
            if (req_lock_in) lock_r <= 1'b1;                                    // [RULE_07] [RULE_08]
            state_r <= ST_T1;
          end
        end
        ST_T1: if (ph_end) state_r <= ST_T2;
        ST_T2: if (ready_hit) begin
          unique case (kind_r)
            CYC_MEM: if (split_need) begin
              second_r <= 1'b1;  hw_r <= 1'b0;  na_r <= 1'b0;                   // [RULE_05]
              be_n_r  <= {be_n_r[3:2], 2'h3};
              wdata_r <= {wdata_r[31:16], wdata_r[31:16]};
              rlow_r  <= d_lo;                                                  // [RULE_04]
              state_r <= ST_T1;
            end else begin
              done_out <= 1'b1;                                                 // [RULE_23]
              if (!hw_r) rdata_out <= s_data;
              else if (second_r || upper_only) rdata_out <= {d_lo, rlow_r};     // [RULE_01] [RULE_02]
              else rdata_out <= {16'h0, d_lo};
              if (lockcyc_r && lock_last_r) lock_r <= 1'b0;                     // [RULE_08]
              state_r <= ST_IDLE;
            end
            CYC_INTA1: begin
              gap_r   <= clock_doubled_in ? IDLE_GAP_DOUBLED : IDLE_GAP_NORMAL; // [RULE_12]
              state_r <= ST_GAP;
            end
            CYC_INTA2: begin
              vector_out       <= d_lo[7:0];                                    // [RULE_13]
              vector_valid_out <= 1'b1;
              lock_r           <= 1'b0;                                         // [RULE_12]
              int_armed_r      <= 1'b0;
              state_r          <= ST_IDLE;
            end
            CYC_HALT: state_r <= ST_HALT;                                       // [RULE_15]
            CYC_SHUT: state_r <= ST_SHUT;                                       // [RULE_17]
          endcase
        end
        ST_GAP: if (ph_end) begin
          if (gap_r == 4'h1) begin
            kind_r <= CYC_INTA2;  addr_r <= INTA2_ADDR;  be_n_r <= INTA_BE_N;   // [RULE_10] [RULE_11]
            hw_r <= 1'b0;  na_r <= 1'b0;  state_r <= ST_T1;
          end else begin
            gap_r <= gap_r - 4'h1;
          end
        end
        ST_HALT: if ((s_maskable_int_req && int_enable_in) || s_nmi || s_smi) state_r <= ST_IDLE;  // [RULE_15]
        ST_SHUT: if (s_nmi) state_r <= ST_IDLE;                                 // [RULE_17]
      endcase
      if (halt_req_in) halt_pend_r <= 1'b1;
      if (shutdown_req_in) shut_pend_r <= 1'b1;
    end
  end

  // Valid bits and replacement; invalidation clears the whole cache
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || inv_now) begin                                             // [RULE_21]
      valid_r <= '{default: 2'h0};
      lru_r   <= '{default: 1'b0};
    end else if (ce_in && fill_ok) begin
      valid_r[f_way][f_set] <= f_keep | f_halves;                               // [RULE_18]
      lru_r[f_set]          <= !f_way;
    end
  end

  always_ff @(posedge clock_in) begin
    if (ce_in && fill_ok) begin
      tag_r[f_way][f_set] <= f_tag;
      for (int h = 0; h < 2; h++) begin
        if (f_halves[h]) cdata_r[f_way][f_set][h*16 +: 16] <= f_data[h*16 +: 16];  // [RULE_20]
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      lookup_hit_halves_out <= 2'h0;
      lookup_data_out       <= 32'h0;
    end else if (ce_in) begin
      lookup_hit_halves_out <= l_hit1 ? valid_r[1][l_set] :
                               (way_hit(1'b0, l_set, l_tag) ? valid_r[0][l_set] : 2'h0);
      lookup_data_out       <= l_hit1 ? cdata_r[1][l_set] : cdata_r[0][l_set];
    end
  end

endmodule : cpu_bus_dev

// File: verification/cpu_bus_checker_sva.sv
`timescale 1ns/1ps
module cpu_bus_checker (
  input wire logic        clock_in, rst_n_in, addr_strobe_n, mem_io, data_ctrl, write_rd,
  input wire logic        bus_lock_n, cycle_done_n, flush_req_n,
  input wire logic [29:0] addr,
  input wire logic [3:0]  byte_lane_enables_n
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire [2:0] df = {mem_io, data_ctrl, write_rd};
  wire       st = !addr_strobe_n;
  wire [3:0] be = byte_lane_enables_n;
  AST_HALT: assert property (st && df == 3'h5 && be == 4'hb |-> ~|addr && bus_lock_n)
    else $error("halt cycle wrong");
  AST_SHUT: assert property (st && df == 3'h5 && be == 4'he |-> ~|addr && bus_lock_n)
    else $error("shutdown cycle wrong");
  AST_INTA: assert property (st && df == 3'h0 |-> be == 4'he && !bus_lock_n && ~|addr[29:1])
    else $error("acknowledge cycle wrong");
  AST_LOCK: assert property ($fell(bus_lock_n) |-> st)
    else $error("lock not at cycle start");
  AST_STRB: assert property ($fell(addr_strobe_n) |=> st ##1 !st)
    else $error("first state length wrong");
  AST_DONE: assert property ($fell(cycle_done_n) |=> !cycle_done_n ##1 cycle_done_n)
    else $error("completion length wrong");
  AST_FLSH: assert property ($fell(flush_req_n) |=> !flush_req_n)
    else $error("flush too short");
  AST_GAP: assert property ($rose(cycle_done_n) && df == 3'h0 && addr == 30'h1 |->
    (!st && !bus_lock_n) [*6]) else $error("acknowledge gap wrong");
  cover property (st && df == 3'h0 && ~|addr);
  cover property (st && df == 3'h5);
  cover property ($fell(flush_req_n));
endmodule : cpu_bus_checker

// File: verification/cpu_bus_special_cycles_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
`define WT(s) begin do @(negedge clk); while ((s) !== 1'b1); @(posedge clk); end
module cpu_bus_special_cycles_tb;
  logic clk, rst_n, rv, rw, rl, rll, hr, sr, ir, ie, cd, hw, na, irq, nmi, smi, fl, nc, pb;
  logic fe, ce, rdy, done, vv, halt_instruction, sd, cv, lk, ia;
  logic [29:0] ra, la, ca, ad;
  logic [31:0] rwd, rdd, ld, rdo, cw, d, m, dq[$];
  logic [3:0] rbe, ws, cb;
  logic [7:0] iv, vec;
  logic [2:0] cdf;
  logic [1:0] hh;
  logic [53:0] n, cq[$];
  int seed, i, cyc = 0, miscompares = 0, checks_done = 0;
  cpu_bus_if bus_if ();
  cpu_bus_dev i_cpu_bus_dev (.clock_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .bus(bus_if.dev),
    .req_valid_in(rv), .req_ready_out(rdy), .req_write_in(rw), .req_mem_in(1'b1),
    .req_addr_in(ra), .req_be_n_in(rbe), .req_wdata_in(rwd), .req_lock_in(rl),
    .req_lock_last_in(rll), .req_noncache_in(nc), .done_out(done), .rdata_out(rdo),
    .int_enable_in(ie), .clock_doubled_in(cd), .halt_req_in(hr), .shutdown_req_in(sr),
    .invalidate_req_in(ir), .hold_grant_in(1'b0), .cache_enable_pin_bit_in(pb),
    .invalidate_on_hold_bit_in(1'b0), .flush_enable_bit_in(fe), .vector_valid_out(vv),
    .vector_out(vec), .halted_out(halt_instruction), .shut_down_out(sd), .lookup_addr_in(la),
    .lookup_hit_halves_out(hh), .lookup_data_out(ld));
  cpu_bus_sys i_cpu_bus_sys (.clock_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .bus(bus_if.sys),
    .wait_states_in(ws), .half_width_mode_in(hw), .next_addr_mode_in(na),
    .cache_enable_mode_in(ce), .rd_data_in(rdd), .int_req_in(irq), .int_vector_in(iv),
    .nmi_in(nmi), .mgmt_int_in(smi), .flush_in(fl), .cyc_valid_out(cv), .cyc_addr_out(ca),
    .cyc_be_n_out(cb), .cyc_def_out(cdf), .cyc_locked_out(lk), .cyc_wdata_out(cw),
    .int_ack_out(ia));
  cpu_bus_checker i_cpu_bus_checker (.clock_in(clk), .rst_n_in(rst_n), .addr(bus_if.addr),
    .byte_lane_enables_n(bus_if.byte_lane_enables_n), .addr_strobe_n(bus_if.addr_strobe_n),
    .mem_io(bus_if.mem_io), .data_ctrl(bus_if.data_ctrl), .write_rd(bus_if.write_rd),
    .bus_lock_n(bus_if.bus_lock_n), .cycle_done_n(bus_if.cycle_done_n),
    .flush_req_n(bus_if.flush_req_n));
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic note(input logic [29:0] a, input logic [3:0] b, input logic [2:0] f,
      input logic l, input logic [15:0] w);
    cq.push_back({a, b, f, l, w});
  endtask : note
  task automatic req(input logic w, input logic [3:0] b, input logic l, input logic ll);
    {rw, rbe, rl, rll, ra, rwd, rv} <= {w, b, l, ll, ad, d, 1'b1};
    `WT(rdy)
    rv <= 1'b0;
    `WT(done)
  endtask : req
  task automatic rd(input logic l, input logic ll);
    note(ad, 4'h0, 3'h6, l, 16'h0);
    if (hw) note(ad, 4'h3, 3'h6, l, 16'h0);
    dq.push_back(hw ? {2{d[15:0]}} : d);
    rdd <= d;
    req(1'b0, 4'h0, l, ll);
  endtask : rd
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results;
    end
  end
  // Bus cycles are matched against the notes, and results against dq, in order
  always @(negedge clk) begin
    if (cv === 1'b1) begin
      n = (cq.size() > 0) ? cq.pop_front() : '1;
      `CHK({ca, cb, cdf, lk}, n[53:16])
      if (n[17]) `CHK(cw[15:0], n[15:0])
      `CHK(ia, n[53:16] == {30'h0, 4'he, 3'h0, 1'b1})
    end
    if (done === 1'b1 && dq.size() > 0) begin
      m = dq.pop_front();
      `CHK(rdo, m)
    end
    if (vv === 1'b1) begin
      m = dq.pop_front();
      `CHK({24'h0, vec}, m)
    end
  end
  initial begin
    seed = 92831;
    {rv, rw, rl, rll, hr, sr, ir, ie, cd, hw, na, irq, nmi, smi, fl, nc, rst_n} <= '0;
    {pb, fe, ce, ra, la, rbe, ws, rwd, rdd, iv} <= {3'h7, 140'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++) begin
      ad = 30'($random(seed));
      d = $random(seed);
      ws <= {2'h0, ad[1:0]};
      if (i % 2) note(ad, 4'h0, 3'h7, 1'b0, d[15:0]);
      if (i % 2) req(1'b1, 4'h0, 1'b0, 1'b0);
      else rd(1'b0, 1'b0);
    end
    {hw, na} <= 2'h3;
    note(ad, 4'h0, 3'h7, 1'b0, d[15:0]);
    note(ad, 4'h3, 3'h7, 1'b0, d[31:16]);
    req(1'b1, 4'h0, 1'b0, 1'b0);
    note(ad, 4'h3, 3'h7, 1'b0, d[31:16]);
    req(1'b1, 4'h3, 1'b0, 1'b0);
    rd(1'b1, 1'b0);
    {hw, na} <= 2'h0;
    note(ad, 4'h0, 3'h7, 1'b1, d[15:0]);
    req(1'b1, 4'h0, 1'b1, 1'b1);
    for (i = 0; i < 3; i++) begin
      ad = 30'($random(seed));
      d = $random(seed);
      {la, nc} <= {ad, i == 0};
      rd(1'b0, 1'b0);
      repeat (2) @(negedge clk);
      `CHK(hh, (i == 0) ? 2'h0 : 2'h3)
      if (i > 0) `CHK(ld, d)
      @(posedge clk);
      {fl, ir} <= {i == 2, i == 1};
      @(posedge clk);
      {fl, ir, nc} <= 3'h0;
      repeat (10) @(negedge clk);
      `CHK(hh, 2'h0)
      @(posedge clk);
    end
    for (i = 0; i < 2; i++) begin
      d = $random(seed);
      {ie, cd, iv, irq} <= {1'b1, i[0], d[7:0], 1'b1};
      note(30'h1, 4'he, 3'h0, 1'b1, 16'h0);
      note(30'h0, 4'he, 3'h0, 1'b1, 16'h0);
      dq.push_back({24'h0, d[7:0]});
      `WT(vv)
      irq <= 1'b0;
      repeat (8) @(posedge clk);
    end
    ie <= 1'b0;
    note(30'h0, 4'hb, 3'h5, 1'b0, 16'hffff);
    hr <= 1'b1;
    @(posedge clk);
    hr <= 1'b0;
    `WT(halt_instruction)
    smi <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(halt_instruction, 1'b0)
    @(posedge clk);
    {smi, sr} <= 2'h1;
    note(30'h0, 4'he, 3'h5, 1'b0, 16'hffff);
    @(posedge clk);
    sr <= 1'b0;
    `WT(sd)
    smi <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK(sd, 1'b1)
    @(posedge clk);
    {smi, nmi} <= 2'h1;
    repeat (8) @(negedge clk);
    `CHK(sd, 1'b0)
    `CHK(cq.size(), 0)
    results;
  end
endmodule : cpu_bus_special_cycles_tb
